/* File: hdl/spi_port_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH
`define SPI_CFG_ADDR        13'h0000
`define SPI_RB_ADDR         13'h0004
`define SPI_UPD_ADDR        13'h0005
`define SPI_CFG_LSB_BIT     6
`define SPI_CFG_UNIDIR_BIT  7
`define SPI_RB_BIT          0
`define SPI_UPD_BIT         0
`define SPI_CFG_RESET       8'h00
`define SPI_RB_RESET        1'b0
`define SPI_MAP_RESET       8'h00
`define INSTR_RW_BIT        15
`define INSTR_CNT_MSB       14
`define INSTR_CNT_LSB       13
`define INSTR_ADDR_MSB      12
`define CNT_STREAM          2'h3
`define I2C_ADDR_BASE       7'h68
`define STRAP_LOW           2'h0
`define STRAP_OPEN          2'h1
`define HOST_INSTR_OFS      8'h00
`define HOST_TX_OFS         8'h04
`define HOST_RX_OFS         8'h08
`define HOST_STAT_OFS       8'h0c
`define HOST_LSB_BIT        16
`define HOST_UNIDIR_BIT     17
`define HOST_STALL_BIT      18
`define CLK_PERIOD_NS       40
`define LINK_HALF_NS        320
`define LINK_HALF_CYC ((`LINK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: hdl/spi_port_pkg.sv */
// Types shared by the serial control port target and its host.
package spi_port_pkg;
  typedef logic [12:0] reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
  typedef enum {st_idle, st_instr, st_write, st_read, st_done} dev_state_t;
  typedef enum {h_idle, h_start, h_low, h_high, h_stall, h_end} host_state_t;
endpackage

/* File: hdl/spi_link_if.sv */
// Serial link between the control port target and its host.
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic dev_sdo_o;
  logic dev_sdo_oe_n;
  logic sdio_line;
  logic sdo_line;

  // Resolve the shared pins; an undriven line floats high on its pull-up.
  assign sdio_line = !dev_sdio_oe_n ? dev_sdio_o :
                     (!host_sdio_oe_n ? host_sdio_o : 1'b1);
  assign sdo_line  = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;

  modport target (input sclk, input cs_n, input sdio_line,
                  output dev_sdio_o, output dev_sdio_oe_n,
                  output dev_sdo_o, output dev_sdo_oe_n);
  modport host (output sclk, output cs_n, output host_sdio_o,
                output host_sdio_oe_n, input sdio_line, input sdo_line);
endinterface
`default_nettype wire

/* File: hdl/spi_target.sv */
// Serial control port target: strap decode, SPI engine, staged registers.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_regs.svh"
// Function
// - Straps choose SPI or one of eight I2C addresses.
// - Protocol choice is frozen until the next reset.
// - Sample on rising, present read on falling.
// - Bidirectional shared pin or separate output pin.
// - Chip select high releases both data pins.
// - Reset gives bidirectional, MSB-first operation.
// - Short transfers stall at byte boundaries, resume.
// - Abort by completing or short chip-select burst.
// - Chip select rise mid-byte discards and resets.
// - Streaming runs unbounded until chip select rises.
// - Byte count: one, two, three or streaming.
// - Sixteen-bit instruction precedes every payload.
// - Multibyte access never skips any address.
// - Writes land in staging; update copies to active.
// - Update register bit 0 triggers, self clears.
// - External update pin also triggers the copy.
// - Read returns N bytes from start address.
// - Readback select picks staging or active copy.
// - Port config register lives inside SPI logic.
// - Instruction: direction, count, 13-bit address.
// - Config bit 6: LSB first and ascending address.
module spi_target #(
  parameter int MAP_WORDS = 32
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    pin_control_strap_i,
  input  wire logic [1:0]              port_select_strap_low_i,
  input  wire logic [1:0]              port_select_strap_high_i,
  input  wire logic                    io_update_pin_i,
  input  wire spi_port_pkg::reg_addr_t act_addr_i,
  output var  spi_port_pkg::reg_byte_t act_data_o,
  output var  logic                    spi_selected_o,
  output var  logic                    i2c_selected_o,
  output var  logic [6:0]              i2c_address_o,
  output var  logic                    io_update_o,
  spi_link_if.target                   link
);
  import spi_port_pkg::*;

  localparam int IW = $clog2(MAP_WORDS);
  localparam logic [13:0] MAP_TOP = 14'(MAP_WORDS);

  // --------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------
  if (MAP_WORDS < 8 || MAP_WORDS > 8192 ||
      (MAP_WORDS & (MAP_WORDS - 1)) != 0) begin : g_bad_map
    $error("MAP_WORDS must be a power of two from 8 to 8192.");
  end

  logic [8:0]  sync_a;
  logic [8:0]  sync_b;
  logic [3:0]  prev;
  logic        strap_taken;
  logic [3:0]  strap_idx;
  dev_state_t  state;
  logic [3:0]  bit_cnt;
  logic [15:0] instr;
  logic [7:0]  rx_sh;
  logic [7:0]  tx;
  logic        out_bit;
  logic        streaming;
  logic [1:0]  bytes_left;
  reg_addr_t   addr;
  reg_byte_t   cfg;
  logic        rb_sel;
  reg_byte_t   staged [MAP_WORDS];
  reg_byte_t   active [MAP_WORDS];
  logic        sdio_oe_n;
  logic        sdo_oe_n;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_n;
  logic        sdi;
  logic        rise_ok;
  logic        lsb_first;
  logic        unidir;
  logic [15:0] in_word;
  reg_byte_t   in_byte;
  reg_addr_t   addr_step;
  logic        wr_fire;
  logic        upd_req;
  logic        drive_rd;

  // --------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------

  // Every pin passes two flip-flops; edges are found after the second.
  always_ff @(posedge clk_i) begin
    sync_a <= {port_select_strap_high_i, port_select_strap_low_i,
               pin_control_strap_i, io_update_pin_i, link.sdio_line,
               link.cs_n, link.sclk};
    sync_b <= sync_a;
    prev   <= sync_b[3:0];
  end

  // Link clock edges and the link-side levels seen by the engine.
  assign sclk_rise = sync_b[0] & ~prev[0];
  assign sclk_fall = ~sync_b[0] & prev[0];
  assign cs_n      = sync_b[1];
  assign sdi       = sync_b[2];
  assign rise_ok   = sclk_rise & ~cs_n;
  assign upd_req   = (sync_b[3] & ~prev[3]) |
                     (wr_fire && addr == `SPI_UPD_ADDR &&
                      in_byte[`SPI_UPD_BIT]);

  // --------------------------------------------------------------
  // Strap decode
  // --------------------------------------------------------------

  // Maps a three-level strap code to 0, 1 or 2.
  function automatic logic [3:0] level(input logic [1:0] s);
    case (s)
      `STRAP_LOW:  level = 4'h0;
      `STRAP_OPEN: level = 4'h1;
      default:     level = 4'h2;
    endcase
  endfunction

  assign strap_idx = 4'(level(sync_b[8:7]) * 4'h3 + level(sync_b[6:5]));

  // Straps are caught once after reset release and then held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_taken    <= 1'b0;
      spi_selected_o <= 1'b0;
      i2c_selected_o <= 1'b0;
      i2c_address_o  <= 7'h00;
    end else if (!strap_taken) begin
      strap_taken    <= 1'b1;
      spi_selected_o <= !sync_b[4] && strap_idx == 4'h0;
      i2c_selected_o <= !sync_b[4] && strap_idx != 4'h0;
      i2c_address_o  <= `I2C_ADDR_BASE + 7'(strap_idx - 4'h1);
    end
  end

  // --------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------

  // Bit order and address direction follow the port config register.
  assign lsb_first = cfg[`SPI_CFG_LSB_BIT];
  assign unidir    = cfg[`SPI_CFG_UNIDIR_BIT];
  assign in_word   = lsb_first ? {sdi, instr[15:1]} : {instr[14:0], sdi};
  assign in_byte   = lsb_first ? {sdi, rx_sh[7:1]} : {rx_sh[6:0], sdi};
  assign addr_step = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
  assign wr_fire   = rise_ok && state == st_write && bit_cnt[2:0] == 3'h7;

  // Value returned for a read of one address.
  function automatic reg_byte_t rd_value(input reg_addr_t a);
    if (a == `SPI_CFG_ADDR) rd_value = cfg;
    else if (a == `SPI_RB_ADDR) rd_value = {7'h00, rb_sel};
    else if (a == `SPI_UPD_ADDR) rd_value = 8'h00;
    else if ({1'b0, a} >= MAP_TOP) rd_value = 8'h00;
    else if (rb_sel) rd_value = active[a[IW-1:0]];
    else rd_value = staged[a[IW-1:0]];
  endfunction

  // Transfer sequencing: instruction, payload, stall and abort.
  always_ff @(posedge clk_i) begin
    if (rst_i || !spi_selected_o) begin
      state      <= st_idle;
      bit_cnt    <= 4'h0;
      instr      <= 16'h0000;
      rx_sh      <= 8'h00;
      streaming  <= 1'b0;
      bytes_left <= 2'h0;
      addr       <= 13'h0000;
    end else if (cs_n) begin
      if (bit_cnt[2:0] != 3'h0) begin
        state   <= st_idle;
        bit_cnt <= 4'h0;
      end else if (state == st_done || streaming) begin
        state <= st_idle;
      end                                          // Otherwise stall.
    end else begin
      case (state)
        st_idle: begin
          state     <= st_instr;
          bit_cnt   <= 4'h0;
          streaming <= 1'b0;
        end
        st_instr: if (rise_ok) begin
          instr   <= in_word;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf) begin
            bit_cnt    <= 4'h0;
            addr       <= in_word[`INSTR_ADDR_MSB:0];
            bytes_left <= in_word[`INSTR_CNT_MSB:`INSTR_CNT_LSB];
            streaming  <= in_word[`INSTR_CNT_MSB:`INSTR_CNT_LSB] ==
                          `CNT_STREAM;
            state      <= in_word[`INSTR_RW_BIT] ? st_read : st_write;
          end
        end
        st_write, st_read: if (rise_ok) begin
          rx_sh   <= in_byte;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt[2:0] == 3'h7) begin
            bit_cnt <= 4'h0;
            addr    <= addr_step;
            if (!streaming) begin
              if (bytes_left == 2'h0) state <= st_done;
              else bytes_left <= bytes_left - 2'h1;
            end
          end
        end
        st_done: state <= st_done;
        default: state <= st_idle;
      endcase
    end
  end

  // Read shifter: load at byte starts, present one bit per falling edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx      <= 8'h00;
      out_bit <= 1'b0;
    end else if (rise_ok && state == st_instr && bit_cnt == 4'hf) begin
      tx <= rd_value(in_word[`INSTR_ADDR_MSB:0]);
    end else if (rise_ok && state == st_read && bit_cnt[2:0] == 3'h7) begin
      tx <= rd_value(addr_step);
    end else if (sclk_fall && !cs_n && state == st_read) begin
      out_bit <= lsb_first ? tx[0] : tx[7];
      tx      <= lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
    end
  end

  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------

  // Config, readback select, staging copy and the active copy.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg         <= `SPI_CFG_RESET;
      rb_sel      <= `SPI_RB_RESET;
      staged      <= '{default: `SPI_MAP_RESET};
      active      <= '{default: `SPI_MAP_RESET};
      io_update_o <= 1'b0;
    end else begin
      io_update_o <= upd_req;
      if (wr_fire) begin
        if (addr == `SPI_CFG_ADDR) cfg <= in_byte;
        else if (addr == `SPI_RB_ADDR) rb_sel <= in_byte[`SPI_RB_BIT];
        else if (addr != `SPI_UPD_ADDR && {1'b0, addr} < MAP_TOP)
          staged[addr[IW-1:0]] <= in_byte;
      end
      if (upd_req) active <= staged;
    end
  end

  // Active contents seen by the rest of the device.
  always_ff @(posedge clk_i) begin
    if (rst_i) act_data_o <= 8'h00;
    else if ({1'b0, act_addr_i} < MAP_TOP)
      act_data_o <= active[act_addr_i[IW-1:0]];
    else act_data_o <= 8'h00;
  end

  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------

  assign drive_rd = !cs_n && state == st_read;

  // Only one data pin drives, and only from the first read bit on: the host
  // holds the shared pin until the fall after its last instruction bit, so
  // enabling at the end of the instruction would fight it.
  always_ff @(posedge clk_i) begin
    if (rst_i || !drive_rd) begin
      sdio_oe_n <= 1'b1;
      sdo_oe_n  <= 1'b1;
    end else if (sclk_fall) begin
      sdio_oe_n <= unidir;
      sdo_oe_n  <= !unidir;
    end
  end

  assign link.dev_sdio_o    = out_bit;
  assign link.dev_sdo_o     = out_bit;
  assign link.dev_sdio_oe_n = sdio_oe_n;
  assign link.dev_sdo_oe_n  = sdo_oe_n;
endmodule // spi_target
`default_nettype wire

/* File: hdl/spi_host.sv */
// SPI controller end: Wishbone registers in, serial transfers out.
`timescale 1ns/100ps
`default_nettype none
`include "spi_port_regs.svh"
module spi_host #(
  parameter int HALF_CYC = `LINK_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output var  logic        ack_o,
  spi_link_if.host         link
);
  import spi_port_pkg::*;

  localparam logic [5:0] HALF_END = 6'(HALF_CYC - 1);
  localparam logic [5:0] GAP_END  = 6'(2 * HALF_CYC - 1);

  // --------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------
  if (HALF_CYC < 8 || HALF_CYC > 31) begin : g_bad_half
    $error("HALF_CYC must lie from 8 to 31 clock cycles.");
  end

  logic [15:0] instr_q;
  logic        lsb;
  logic        unidir;
  logic        stall_en;
  logic [31:0] txd;
  logic [31:0] rxd;
  logic        launch;
  logic        busy;
  host_state_t hstate;
  logic [5:0]  ph;
  logic [5:0]  bit_i;
  logic [5:0]  next_i;
  logic [5:0]  last_bit;
  logic [5:0]  j;
  logic [1:0]  miso_a;
  logic [1:0]  miso_b;
  logic        miso;
  logic        rd;
  logic        req;

  // --------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------

  assign req = cyc_i & stb_i & ~ack_o;

  // One-cycle answer; writes honour byte lanes; unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
      instr_q  <= 16'h0000;
      lsb      <= 1'b0;
      unidir   <= 1'b0;
      stall_en <= 1'b0;
      txd      <= 32'h0000_0000;
      launch   <= 1'b0;
    end else begin
      ack_o  <= req;
      launch <= 1'b0;
      if (req && we_i && adr_i == `HOST_INSTR_OFS && !busy) begin
        if (sel_i[0]) instr_q[7:0] <= dat_i[7:0];
        if (sel_i[1]) instr_q[15:8] <= dat_i[15:8];
        if (sel_i[2]) begin
          lsb      <= dat_i[`HOST_LSB_BIT];
          unidir   <= dat_i[`HOST_UNIDIR_BIT];
          stall_en <= dat_i[`HOST_STALL_BIT];
        end
        launch <= 1'b1;
      end
      if (req && we_i && adr_i == `HOST_TX_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) txd[8*b +: 8] <= dat_i[8*b +: 8];
        end
      end
      if (req && !we_i) begin
        case (adr_i)
          `HOST_INSTR_OFS: dat_o <= {13'h0000, stall_en, unidir, lsb,
                                     instr_q};
          `HOST_TX_OFS:    dat_o <= txd;
          `HOST_RX_OFS:    dat_o <= rxd;
          `HOST_STAT_OFS:  dat_o <= {31'h0000_0000, busy};
          default:         dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Serial sequencer
  // --------------------------------------------------------------

  // Read data pins pass two flip-flops before use.
  always_ff @(posedge clk_i) begin
    miso_a <= {link.sdo_line, link.sdio_line};
    miso_b <= miso_a;
  end

  assign miso     = unidir ? miso_b[1] : miso_b[0];
  assign rd       = instr_q[`INSTR_RW_BIT];
  assign next_i   = bit_i + 6'h01;
  assign j        = bit_i - 6'h10;
  assign last_bit = (instr_q[`INSTR_CNT_MSB:`INSTR_CNT_LSB] == `CNT_STREAM)
                    ? 6'h2f
                    : 6'h17 + 6'({instr_q[`INSTR_CNT_MSB:`INSTR_CNT_LSB],
                                  3'h0});

  // Bit sent in position i: instruction first, then payload bytes.
  function automatic logic tx_bit(input logic [5:0] i);
    logic [5:0] k;
    k = i - 6'h10;
    if (i < 6'h10) tx_bit = instr_q[lsb ? i[3:0] : ~i[3:0]];
    else tx_bit = txd[{k[4:3], lsb ? k[2:0] : ~k[2:0]}];
  endfunction

  // Drives data on falling edges and samples read data before rising.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hstate              <= h_idle;
      link.sclk           <= 1'b0;
      link.cs_n           <= 1'b1;
      link.host_sdio_o    <= 1'b0;
      link.host_sdio_oe_n <= 1'b1;
      ph                  <= 6'h00;
      bit_i               <= 6'h00;
      busy                <= 1'b0;
      rxd                 <= 32'h0000_0000;
    end else begin
      ph <= ph + 6'h01;
      case (hstate)
        h_idle: begin
          ph <= 6'h00;
          if (launch) begin
            busy   <= 1'b1;
            hstate <= h_start;
          end
        end
        h_start: begin
          link.cs_n           <= 1'b0;
          link.host_sdio_o    <= tx_bit(6'h00);
          link.host_sdio_oe_n <= 1'b0;
          bit_i               <= 6'h00;
          rxd                 <= 32'h0000_0000;
          ph                  <= 6'h00;
          hstate              <= h_low;
        end
        h_low: if (ph == HALF_END) begin
          ph        <= 6'h00;
          link.sclk <= 1'b1;
          hstate    <= h_high;
          if (rd && bit_i >= 6'h10)
            rxd[{j[4:3], lsb ? j[2:0] : ~j[2:0]}] <= miso;
        end
        h_high: if (ph == HALF_END) begin
          ph        <= 6'h00;
          link.sclk <= 1'b0;
          if (bit_i == last_bit) begin
            hstate <= h_end;
          end else begin
            bit_i               <= next_i;
            link.host_sdio_o    <= tx_bit(next_i);
            link.host_sdio_oe_n <= rd && next_i >= 6'h10 && !unidir;
            if (stall_en && bit_i[2:0] == 3'h7 &&
                instr_q[`INSTR_CNT_MSB:`INSTR_CNT_LSB] != `CNT_STREAM) begin
              link.cs_n <= 1'b1;
              hstate    <= h_stall;
            end else begin
              hstate <= h_low;
            end
          end
        end
        h_stall: if (ph == GAP_END) begin
          ph        <= 6'h00;
          link.cs_n <= 1'b0;
          hstate    <= h_low;
        end
        h_end: begin
          if (ph == HALF_END) link.cs_n <= 1'b1;
          if (ph == GAP_END) begin
            link.host_sdio_oe_n <= 1'b1;
            busy                <= 1'b0;
            hstate              <= h_idle;
          end
        end
        default: hstate <= h_idle;
      endcase
    end
  end
endmodule // spi_host
`default_nettype wire

/* File: verification/spi_port_checker.sv */
// Concurrent checks on the serial link between host and target.
`timescale 1ns/100ps
`default_nettype none
module spi_port_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe_n,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe_n
);
  // --------------------------------------------------------------
  // Link properties, all on the system clock.
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cs_release;
    cs_n [*4] |-> dev_sdio_oe_n && dev_sdo_oe_n;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("data pins driven with chip select high");
  property p_one_pin;
    !(!dev_sdio_oe_n && !dev_sdo_oe_n);
  endproperty
  a_one_pin: assert property (p_one_pin)
    else $error("both data pins driven");
  property p_no_fight;
    !dev_sdio_oe_n |-> host_sdio_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("shared pin driven by both ends");
  property p_rd_on_fall;
    (!dev_sdio_oe_n && $changed(dev_sdio_o)) ||
    (!dev_sdo_oe_n && $changed(dev_sdo_o)) |-> !sclk;
  endproperty
  a_rd_on_fall: assert property (p_rd_on_fall)
    else $error("read bit changed while serial clock high");
  property p_wr_stable;
    sclk && $past(sclk) |-> $stable(host_sdio_o);
  endproperty
  a_wr_stable: assert property (p_wr_stable)
    else $error("write bit changed while serial clock high");
  property p_rise_sel;
    $rose(sclk) |-> !cs_n && $past(!cs_n);
  endproperty
  a_rise_sel: assert property (p_rise_sel)
    else $error("serial clock rose without chip select");
  property p_cs_edge;
    $changed(cs_n) |-> !sclk;
  endproperty
  a_cs_edge: assert property (p_cs_edge)
    else $error("chip select moved with serial clock high");
  property p_high_len;
    $rose(sclk) |=> sclk [*7];
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("serial clock high phase too short");
  c_sdio_read: cover property (!dev_sdio_oe_n);
  c_sdo_read: cover property (!dev_sdo_oe_n);
  c_stall: cover property ($rose(cs_n) ##[1:40] $fell(cs_n));
endmodule // spi_port_checker
`default_nettype wire

/* File: verification/serial_control_port_spi_tb.sv */
// Self-checking bench: host and target joined over the serial link.
`timescale 1ns/100ps
`default_nettype none
module serial_control_port_spi_tb;
  import spi_port_pkg::*;
  logic clk_i = 0, rst_i = 1, upd_pin = 0, pc = 0, spi_sel, i2c_sel, ack;
  logic [1:0] sl = 0, sh = 0;
  logic [6:0] i2c_adr;
  logic [7:0] adr = 0;
  logic [31:0] dat_w = 0, dat_r, rx;
  logic we = 0, cyc = 0, stb = 0;
  logic [3:0] sel = 0;
  reg_addr_t act_addr = 0;
  reg_byte_t act_data;
  int error_cnt = 0, n_checks = 0;
  spi_link_if spi_link_if_inst ();
  spi_target spi_target_inst (.clk_i(clk_i), .rst_i(rst_i),
    .pin_control_strap_i(pc), .port_select_strap_low_i(sl),
    .port_select_strap_high_i(sh), .io_update_pin_i(upd_pin),
    .act_addr_i(act_addr), .act_data_o(act_data),
    .spi_selected_o(spi_sel), .i2c_selected_o(i2c_sel),
    .i2c_address_o(i2c_adr), .io_update_o(), .link(spi_link_if_inst));
  spi_host spi_host_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat_w), .dat_o(dat_r), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .link(spi_link_if_inst));
  spi_port_checker spi_port_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(spi_link_if_inst.sclk), .cs_n(spi_link_if_inst.cs_n),
    .host_sdio_o(spi_link_if_inst.host_sdio_o),
    .host_sdio_oe_n(spi_link_if_inst.host_sdio_oe_n),
    .dev_sdio_o(spi_link_if_inst.dev_sdio_o),
    .dev_sdio_oe_n(spi_link_if_inst.dev_sdio_oe_n),
    .dev_sdo_o(spi_link_if_inst.dev_sdo_o),
    .dev_sdo_oe_n(spi_link_if_inst.dev_sdo_oe_n));
  // ------------------------------------------------------------
  // Clock, bus tasks and comparison.
  // ------------------------------------------------------------
  // The system clock toggles every 20 ns, giving a period of 40 ns.
  always #20 clk_i = !clk_i;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic reset_all;
    rst_i <= 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  // One classic cycle; data is taken at the rising edge that sees ack high,
  // and the request is released at that same edge.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_r;
    {cyc, stb} <= 2'b00;
  endtask
  // Loads payload, launches, polls busy, fetches received bytes.
  task automatic xfer(input logic [15:0] ins, input logic [2:0] m,
                      input logic [31:0] tx, output logic [31:0] q);
    int n;
    wb(1, 8'h04, tx, q);
    wb(1, 8'h00, {13'h0, m, ins}, q);
    n = 0;
    q = 1;
    while (q[0] !== 1'b0 && n < 500) begin
      wb(0, 8'h0c, 0, q);
      n++;
    end
    if (n == 500) error_cnt++;
    wb(0, 8'h08, 0, q);
  endtask
  task automatic act(input reg_addr_t a, input reg_byte_t e);
    act_addr <= a;
    repeat (3) @(posedge clk_i);
    chk("active", {24'h0, e}, {24'h0, act_data});
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_msb_stage;
    chk("spi_sel", 1, spi_sel);
    wb(0, 8'h10, 0, rx);
    chk("unmapped", 0, rx);
    xfer(16'h2011, 3'b000, 32'hb1a5, rx);
    xfer(16'ha011, 3'b000, 0, rx);
    chk("stage_rd", 16'hb1a5, rx[15:0]);
    act(13'h11, 8'h00);
    xfer(16'h0005, 3'b000, 32'h1, rx);
    act(13'h11, 8'ha5);
    act(13'h10, 8'hb1);
    xfer(16'h8005, 3'b000, 0, rx);
    chk("upd_clear", 0, rx[7:0]);
    xfer(16'h0004, 3'b000, 32'h1, rx);
    xfer(16'h0011, 3'b000, 32'h3c, rx);
    xfer(16'h8011, 3'b000, 0, rx);
    chk("act_rd", 8'ha5, rx[7:0]);
    xfer(16'h0004, 3'b000, 0, rx);
    xfer(16'h8011, 3'b000, 0, rx);
    chk("stage_rd2", 8'h3c, rx[7:0]);
  endtask
  task automatic t_stall;
    xfer(16'h401a, 3'b100, 32'h332211, rx);
    xfer(16'hc01a, 3'b000, 0, rx);
    chk("stall_rd", 24'h332211, rx[23:0]);
  endtask
  task automatic t_lsb_stream;
    xfer(16'h0000, 3'b000, 32'h40, rx);
    xfer(16'h600c, 3'b001, 32'h44332211, rx);
    xfer(16'he00c, 3'b001, 0, rx);
    chk("stream_rd", 32'h44332211, rx);
  endtask
  task automatic t_pin_upd;
    xfer(16'h000c, 3'b001, 32'h99, rx);
    act(13'h0c, 8'h00);
    upd_pin <= 1;
    repeat (6) @(posedge clk_i);
    upd_pin <= 0;
    act(13'h0c, 8'h99);
    act(13'h0d, 8'h22);
  endtask
  task automatic t_unidir;
    xfer(16'h0000, 3'b001, 32'hc0, rx);
    xfer(16'he00c, 3'b011, 0, rx);
    chk("sdo_rd", 32'h44332299, rx);
  endtask
  task automatic t_straps;
    sl <= 2'h1;
    repeat (5) @(posedge clk_i);
    chk("spi_kept", 1, spi_sel);
    for (int i = 1; i < 9; i++) begin
      sh <= 2'(i / 3);
      sl <= 2'(i % 3);
      reset_all();
      chk("i2c_sel", 1, i2c_sel);
      chk("i2c_adr", 7'h67 + 7'(i), i2c_adr);
    end
    // With the pin-control strap high neither protocol is chosen.
    pc <= 1;
    reset_all();
    chk("pc_spi", 0, spi_sel);
    chk("pc_i2c", 0, i2c_sel);
  endtask
  // Main sequence.
  initial begin
    reset_all();
    t_msb_stage();
    t_stall();
    t_lsb_stream();
    t_pin_upd();
    t_unidir();
    t_straps();
    report_and_stop();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
endmodule // serial_control_port_spi_tb
`default_nettype wire
